// ### core/dea_pkg.sv
/*
  shared constants of the data eeprom access block: register offsets,
  bit positions, reset values, unlock keys and write timing.
  assumes a 40 MHz core clock and an 8-bit register port.
*/
package dea_pkg;

    ////////////////////////////////////////////////////////////////////
    // register offsets on the 8-bit register port
    localparam logic [7:0] MEMORY_ACCESS_CONTROL_OFS = 8'h00;
    localparam logic [7:0] WRITE_UNLOCK_PORT_OFS = 8'h01;
    localparam logic [7:0] EEPROM_DATA_BYTE_OFS = 8'h02;
    localparam logic [7:0] EEPROM_LOCATION_SELECT_OFS = 8'h03;
    localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_SECOND_OFS = 8'h04;
    localparam logic [7:0] PERIPHERAL_IRQ_MASK_SECOND_OFS = 8'h05;

    ////////////////////////////////////////////////////////////////////
    // field positions
    localparam int READ_START_POS = 0;
    localparam int WRITE_START_POS = 1;
    localparam int WRITE_PERMIT_POS = 2;
    localparam int WRITE_ABORT_POS = 3;
    localparam int WRITE_DONE_IRQ_POS = 4;

    ////////////////////////////////////////////////////////////////////
    // reset values and fixed data
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'haa;
    localparam int ARRAY_DEPTH = 256;

    ////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int ERASE_TIME_NS = 2000;
    localparam int PROG_TIME_NS = 2000;
    localparam logic [15:0] ERASE_CYCLES =
        16'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] PROG_CYCLES =
        16'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {DEA_IDLE, DEA_ERASE, DEA_PROG} dea_wstate_e;
    typedef enum logic [1:0] {DEA_UL_NONE, DEA_UL_FIRST, DEA_UL_ARMED}
        dea_unlock_e;

endpackage

// ### core/dea_array.sv
/*
  256 x 8 flip-flop array standing in for the eeprom cells.
  assumes one writer at a time; cells keep their contents over reset.
*/
module dea_array
    import dea_pkg::*;
(
    input wire logic sys_clk,
    input wire logic ce,
    input wire logic [7:0] rd_idx,
    output logic [7:0] rd_byte,
    input wire logic wr_en,
    input wire logic [7:0] wr_idx,
    input wire logic [7:0] wr_byte
);

    ////////////////////////////////////////////////////////////////////
    // no reset: contents must survive every reset like real cells
    logic [7:0] cell_q [ARRAY_DEPTH];

    assign rd_byte = cell_q[rd_idx];

    always_ff @(posedge sys_clk) begin
        if (ce && wr_en) begin
            cell_q[wr_idx] <= wr_byte;
        end
    end

endmodule // dea_array

// ### core/dea_timer.sv
/*
  self-timed write duration counter, free of any bus activity.
  assumes start and abort are never both high.
*/
module dea_timer
    import dea_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic start,
    input wire logic abort,
    input wire logic [15:0] load,
    output logic done
);

    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        cnt_d = cnt_q;
        if (abort) begin
            cnt_d = 16'h0000;
        end else if (start) begin
            cnt_d = load;
        end else if (cnt_q != 16'h0000) begin
            cnt_d = cnt_q - 16'h0001;
        end
    end

    assign done = ce && !abort && (cnt_q == 16'h0001);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_q <= 16'h0000;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

endmodule // dea_timer

// ### core/dea_top.sv
/*
  data eeprom access control: register port, unlock sequence, read
  and self-timed erase/program write, abort flag and write-done irq.
  assumes srst is the power-up reset; the reset-pin and watchdog resets
  arrive as synchronous one-cycle-or-longer levels on their own ports.
*/
// Summary of operation
// - the array holds 256 bytes at locations 00h to ffh, all reachable.
// - the data byte carries read or write data; location select picks it.
// - the array is reached only through the four access registers.
// - each byte write first erases the location, then programs it.
// - write duration is counted by an internal timer; completion waits.
// - the unlock port stores nothing and always reads zero.
// - software can only set the read and write start bits, never clear.
// - hardware clears each start bit when its operation ends.
// - writes happen only with write permit set; power-up clears it.
// - a reset-pin or watchdog reset during a write sets the abort flag.
// - such a reset leaves the data and location registers unchanged.
// - a finished write sets the done flag; software or a reset-pin or watchdog reset clears it.
module dea_top
    import dea_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic external_reset_pin_rst,
    input wire logic watchdog_timer_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq
);

    dea_wstate_e wst_q;
    dea_wstate_e wst_d;
    dea_unlock_e ul_q;
    dea_unlock_e ul_d;
    logic rd_busy_q;
    logic rd_busy_d;
    logic permit_q;
    logic permit_d;
    logic abort_q;
    logic abort_d;
    logic done_flag_q;
    logic done_flag_d;
    logic done_mask_q;
    logic done_mask_d;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic [7:0] loc_q;
    logic [7:0] loc_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic soft_rst;
    logic ctrl_wr;
    logic wr_go;
    logic rd_go;
    logic tmr_start;
    logic tmr_done;
    logic [15:0] tmr_load;
    logic mem_we;
    logic [7:0] mem_wbyte;
    logic [7:0] mem_rbyte;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    assign soft_rst = external_reset_pin_rst || watchdog_timer_rst;
    assign ctrl_wr = reg_wr && hit(reg_addr, MEMORY_ACCESS_CONTROL_OFS);

    ////////////////////////////////////////////////////////////////////
    // unlock tracking: any other write breaks the pair
    always_comb begin
        ul_d = ul_q;
        if (soft_rst) begin
            ul_d = DEA_UL_NONE;
        end else if (reg_wr) begin
            if (hit(reg_addr, WRITE_UNLOCK_PORT_OFS) &&
                reg_wdata == UNLOCK_KEY_FIRST) begin
                ul_d = DEA_UL_FIRST;
            end else if (hit(reg_addr, WRITE_UNLOCK_PORT_OFS) &&
                reg_wdata == UNLOCK_KEY_SECOND && ul_q == DEA_UL_FIRST) begin
                ul_d = DEA_UL_ARMED;
            end else begin
                ul_d = DEA_UL_NONE;
            end
        end
    end

    // start needs the armed pair, permit already set and an idle engine
    assign wr_go = !soft_rst && ctrl_wr && reg_wdata[WRITE_START_POS] &&
        ul_q == DEA_UL_ARMED && permit_q && wst_q == DEA_IDLE;
    assign rd_go = !soft_rst && ctrl_wr && reg_wdata[READ_START_POS] &&
        !wr_go && wst_q == DEA_IDLE && !rd_busy_q;

    ////////////////////////////////////////////////////////////////////
    // write engine: erase, then program, each timed
    always_comb begin
        wst_d = wst_q;
        tmr_start = 1'b0;
        tmr_load = ERASE_CYCLES;
        mem_we = 1'b0;
        mem_wbyte = ERASED_BYTE;
        unique case (wst_q)
            DEA_IDLE: begin
                if (wr_go) begin
                    wst_d = DEA_ERASE;
                    tmr_start = 1'b1;
                    mem_we = 1'b1;
                end
            end
            DEA_ERASE: begin
                if (tmr_done) begin
                    wst_d = DEA_PROG;
                    tmr_start = 1'b1;
                    tmr_load = PROG_CYCLES;
                end
            end
            DEA_PROG: begin
                if (tmr_done) begin
                    wst_d = DEA_IDLE;
                    mem_we = 1'b1;
                    mem_wbyte = data_q;
                end
            end
        endcase
        if (soft_rst) begin
            wst_d = DEA_IDLE;
            tmr_start = 1'b0;
            mem_we = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control, data, location, interrupt state
    always_comb begin
        rd_busy_d = rd_busy_q;
        permit_d = permit_q;
        abort_d = abort_q;
        done_flag_d = done_flag_q;
        done_mask_d = done_mask_q;
        data_d = data_q;
        loc_d = loc_q;
        if (rd_busy_q) begin
            rd_busy_d = 1'b0;
            data_d = mem_rbyte;
        end
        if (rd_go) begin
            rd_busy_d = 1'b1;
        end
        if (ctrl_wr) begin
            permit_d = reg_wdata[WRITE_PERMIT_POS];
            abort_d = reg_wdata[WRITE_ABORT_POS];
        end
        // busy engine owns the operands until done
        if (reg_wr && wst_q == DEA_IDLE && !rd_busy_q) begin
            if (hit(reg_addr, EEPROM_DATA_BYTE_OFS)) begin
                data_d = reg_wdata;
            end
            if (hit(reg_addr, EEPROM_LOCATION_SELECT_OFS)) begin
                loc_d = reg_wdata;
            end
        end
        if (reg_wr && hit(reg_addr, PERIPHERAL_IRQ_MASK_SECOND_OFS)) begin
            done_mask_d = reg_wdata[WRITE_DONE_IRQ_POS];
        end
        if (reg_wr && hit(reg_addr, PERIPHERAL_IRQ_FLAGS_SECOND_OFS) &&
            reg_wdata[WRITE_DONE_IRQ_POS]) begin
            done_flag_d = 1'b0;
        end
        // set beats the clear in the same cycle
        if (wst_q == DEA_PROG && tmr_done) begin
            done_flag_d = 1'b1;
        end
        if (soft_rst) begin
            // operands stay so software can redo the same byte
            data_d = data_q;
            loc_d = loc_q;
            rd_busy_d = 1'b0;
            permit_d = 1'b0;
            done_flag_d = 1'b0;
            done_mask_d = 1'b0;
            abort_d = abort_q || (wst_q != DEA_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read-back, one cycle after the strobe
    always_comb begin
        rdata_d = BYTE_RESET;
        if (reg_rd) begin
            unique case (1'b1)
                hit(reg_addr, MEMORY_ACCESS_CONTROL_OFS): begin
                    rdata_d[READ_START_POS] = rd_busy_q;
                    rdata_d[WRITE_START_POS] = wst_q != DEA_IDLE;
                    rdata_d[WRITE_PERMIT_POS] = permit_q;
                    rdata_d[WRITE_ABORT_POS] = abort_q;
                end
                hit(reg_addr, EEPROM_DATA_BYTE_OFS): rdata_d = data_q;
                hit(reg_addr, EEPROM_LOCATION_SELECT_OFS): rdata_d = loc_q;
                hit(reg_addr, PERIPHERAL_IRQ_FLAGS_SECOND_OFS): begin
                    rdata_d[WRITE_DONE_IRQ_POS] = done_flag_q;
                end
                hit(reg_addr, PERIPHERAL_IRQ_MASK_SECOND_OFS): begin
                    rdata_d[WRITE_DONE_IRQ_POS] = done_mask_q;
                end
                // unlock port and unmapped offsets: zero, no array window
                default: rdata_d = BYTE_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wst_q <= DEA_IDLE;
            ul_q <= DEA_UL_NONE;
            rd_busy_q <= 1'b0;
            permit_q <= 1'b0;
            abort_q <= 1'b0;
            done_flag_q <= 1'b0;
            done_mask_q <= 1'b0;
            data_q <= BYTE_RESET;
            loc_q <= BYTE_RESET;
            rdata_q <= BYTE_RESET;
        end else if (ce) begin
            wst_q <= wst_d;
            ul_q <= ul_d;
            rd_busy_q <= rd_busy_d;
            permit_q <= permit_d;
            abort_q <= abort_d;
            done_flag_q <= done_flag_d;
            done_mask_q <= done_mask_d;
            data_q <= data_d;
            loc_q <= loc_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = done_flag_q && done_mask_q;

    ////////////////////////////////////////////////////////////////////
    dea_array u_array (
        .sys_clk(sys_clk),
        .ce(ce),
        .rd_idx(loc_q),
        .rd_byte(mem_rbyte),
        .wr_en(mem_we),
        .wr_idx(loc_q),
        .wr_byte(mem_wbyte)
    );

    dea_timer u_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .ce(ce),
        .start(tmr_start && ce),
        .abort(soft_rst),
        .load(tmr_load),
        .done(tmr_done)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_unlock_reads_zero: assert property (
        reg_rd && ce && hit(reg_addr, WRITE_UNLOCK_PORT_OFS)
        |=> reg_rdata == 8'h00)
        else $error("unlock port read back nonzero");

    a_write_bit_held: assert property (
        ce && wst_q != DEA_IDLE && !soft_rst && !tmr_done && ctrl_wr
        && !reg_wdata[WRITE_START_POS] |=> wst_q != DEA_IDLE)
        else $error("write cleared by software");

    a_read_done_load: assert property (
        ce && rd_busy_q && !soft_rst
        |=> !rd_busy_q && data_q == $past(mem_rbyte))
        else $error("read did not finish with array byte");

    a_start_needs_permit: assert property (
        ce && wst_q == DEA_IDLE && wst_d == DEA_ERASE
        |-> permit_q && ul_q == DEA_UL_ARMED)
        else $error("write started without permit or unlock");

    a_start_needs_unlock: assert property (
        ce && ctrl_wr && reg_wdata[WRITE_START_POS] && ul_q != DEA_UL_ARMED
        && wst_q == DEA_IDLE |=> wst_q == DEA_IDLE)
        else $error("locked write start was taken");

    a_abort_on_reset: assert property (
        ce && soft_rst && wst_q != DEA_IDLE
        |=> abort_q && wst_q == DEA_IDLE)
        else $error("abort flag not set by reset during write");

    a_operands_kept: assert property (
        ce && soft_rst |=> $stable(data_q) && $stable(loc_q))
        else $error("data or location lost on reset");

    a_erase_first: assert property (
        ce && wst_q == DEA_IDLE && wst_d == DEA_ERASE
        |-> mem_we && mem_wbyte == ERASED_BYTE)
        else $error("write did not erase first");

    a_erase_timed: assert property (
        ce && wst_q == DEA_IDLE && wst_d == DEA_ERASE && !soft_rst
        ##1 (ce && !soft_rst) [*8] |-> wst_q == DEA_ERASE)
        else $error("erase ended before timer");

    a_done_flag_set: assert property (
        ce && wst_q == DEA_PROG && tmr_done && !soft_rst
        |=> done_flag_q && wst_q == DEA_IDLE)
        else $error("write done flag not raised");

    a_irq_level: assert property (
        done_flag_q && done_mask_q |-> irq)
        else $error("masked-in flag without irq");

    c_full_write: cover property (
        wst_q == DEA_PROG && tmr_done && ce);
    c_abort_write: cover property (
        soft_rst && ce && wst_q == DEA_ERASE);
    c_read_op: cover property (rd_busy_q && ce);
    c_clear_race: cover property (
        wst_q == DEA_PROG && tmr_done && reg_wr
        && hit(reg_addr, PERIPHERAL_IRQ_FLAGS_SECOND_OFS));

endmodule // dea_top

// ### dv/dea_top_tb.sv
/*
  self-checking bench for dea_top: register port tasks, eeprom reads,
  self-timed writes, unlock pair, abort by reset pin and watchdog, irq.
  assumes the dea_pkg offsets and a 40 MHz clock; ce is held high
  except for one frozen write.
*/
module dea_top_tb
    import dea_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk;
    logic srst;
    logic ce;
    logic external_reset_pin_rst;
    logic watchdog_timer_rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic irq;
    logic [7:0] rdat;
    logic [7:0] locs [2] = '{8'h00, 8'hff};
    logic [7:0] vals [2] = '{8'ha5, 8'h3c};
    int error_cnt = 0;
    int check_count = 0;

    localparam logic [7:0] CTL = MEMORY_ACCESS_CONTROL_OFS;
    localparam logic [7:0] ULK = WRITE_UNLOCK_PORT_OFS;
    localparam logic [7:0] DAT = EEPROM_DATA_BYTE_OFS;
    localparam logic [7:0] LOC = EEPROM_LOCATION_SELECT_OFS;
    localparam logic [7:0] FLG = PERIPHERAL_IRQ_FLAGS_SECOND_OFS;
    localparam logic [7:0] MSK = PERIPHERAL_IRQ_MASK_SECOND_OFS;

    dea_top u_dea_top (
        .sys_clk(sys_clk),
        .srst(srst),
        .ce(ce),
        .external_reset_pin_rst(external_reset_pin_rst),
        .watchdog_timer_rst(watchdog_timer_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands one cycle only, so it is taken mid-cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic irqchk(input logic exp);
        @(negedge sys_clk);
        chk({7'h00, irq}, {7'h00, exp});
    endtask

    task automatic ee_rd(input logic [7:0] loc, input logic [7:0] exp);
        wr(LOC, loc);
        wr(CTL, 8'h01);
        rdchk(DAT, exp);
    endtask

    // permit goes in before the pair: the start write must not set it
    task automatic ee_start(input logic [7:0] loc, input logic [7:0] d);
        wr(LOC, loc);
        wr(DAT, d);
        wr(CTL, 8'h04);
        wr(ULK, UNLOCK_KEY_FIRST);
        wr(ULK, UNLOCK_KEY_SECOND);
        wr(CTL, 8'h06);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        rd(CTL, rdat);
        while (rdat[WRITE_START_POS] !== 1'b0) begin
            n++;
            if (n > 200) begin
                error_cnt++;
                $display("[FAIL] t=%0t got=%h exp=00", $time, rdat);
                close_out();
            end
            rd(CTL, rdat);
        end
    endtask

    task automatic pulse(input int i);
        @(posedge sys_clk);
        if (i == 0) begin
            external_reset_pin_rst <= 1'b1;
        end else begin
            watchdog_timer_rst <= 1'b1;
        end
        @(posedge sys_clk);
        external_reset_pin_rst <= 1'b0;
        watchdog_timer_rst <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        srst = 1'b1;
        ce = 1'b1;
        external_reset_pin_rst = 1'b0;
        watchdog_timer_rst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        for (int a = 0; a < 6; a++) begin
            rdchk(8'(a), BYTE_RESET);
        end
        rdchk(8'h10, 8'h00);
        wr(ULK, UNLOCK_KEY_FIRST);
        rdchk(ULK, 8'h00);
        wr(DAT, 8'h96);
        wr(LOC, 8'h7e);
        rdchk(DAT, 8'h96);
        rdchk(LOC, 8'h7e);
        // a write seen while ce is low must leave the data byte alone
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(DAT, 8'h5c);
        ce <= 1'b1;
        rdchk(DAT, 8'h96);
        $display("test registers done");
        // start without permit, then a pair broken by another write
        wr(CTL, 8'h00);
        wr(ULK, UNLOCK_KEY_FIRST);
        wr(ULK, UNLOCK_KEY_SECOND);
        wr(CTL, 8'h02);
        rdchk(CTL, 8'h00);
        wr(CTL, 8'h04);
        wr(ULK, UNLOCK_KEY_FIRST);
        wr(DAT, 8'h11);
        wr(ULK, UNLOCK_KEY_SECOND);
        wr(CTL, 8'h06);
        rdchk(CTL, 8'h04);
        rdchk(FLG, 8'h00);
        $display("test locked start done");
        for (int i = 0; i < 2; i++) begin
            ee_start(locs[i], vals[i]);
            rdchk(CTL, 8'h06);
            wr(CTL, 8'h04);
            repeat (130) @(posedge sys_clk);
            rdchk(CTL, 8'h06);
            rdchk(FLG, 8'h00);
            wait_done();
            rdchk(CTL, 8'h04);
            irqchk(1'b0);
            ee_rd(locs[i], vals[i]);
            rdchk(FLG, 8'h10);
            wr(MSK, 8'h10);
            irqchk(1'b1);
            wr(FLG, 8'h10);
            irqchk(1'b0);
            rdchk(FLG, 8'h00);
            wr(MSK, 8'h00);
        end
        $display("test write and irq done");
        // cut while erasing; the cell is left erased, not half written
        for (int i = 0; i < 2; i++) begin
            ee_start(8'h10, 8'h5a);
            repeat (20) @(posedge sys_clk);
            pulse(i);
            rdchk(CTL, 8'h08);
            rdchk(DAT, 8'h5a);
            rdchk(LOC, 8'h10);
            ee_rd(8'h10, ERASED_BYTE);
            ee_start(8'h10, 8'h5a);
            wait_done();
            ee_rd(8'h10, 8'h5a);
        end
        // idle engine: the pulse must drop permit and leave abort clear
        wr(CTL, 8'h04);
        pulse(0);
        rdchk(CTL, 8'h00);
        $display("test abort done");
        close_out();
    end

endmodule // dea_top_tb
